/* logic/mburr_pkg.sv */
package mburr_pkg;
    // Protocol address = printed register number minus one
    localparam logic [15:0] MBURR_NUM_TO_ADDR   = 16'h0001;
    localparam logic [15:0] MBURR_WIN_FIRST_NUM = 16'ha779; // 42873
    localparam logic [15:0] MBURR_WIN_LAST_NUM  = 16'ha7f8; // 43000
    localparam int          MBURR_WIN_SLOTS     = 127;
    localparam int          MBURR_SLOT_W        = 7;
    localparam logic [7:0]  MBURR_MAX_WRITE_CNT = 8'h10;    // 16
    localparam logic [7:0]  MBURR_MAX_OBJ_BYTES = 8'h40;    // 64
    localparam logic [7:0]  MBURR_FN_READ_HOLD  = 8'h03;
    localparam logic [7:0]  MBURR_FN_READ_INP   = 8'h04;
    localparam logic [7:0]  MBURR_FN_WRITE_ONE  = 8'h06;
    localparam logic [7:0]  MBURR_FN_WRITE_MANY = 8'h10;
    localparam logic [7:0]  MBURR_EXC_NONE      = 8'h00;
    localparam logic [7:0]  MBURR_EXC_ILL_FUNC  = 8'h01;
    localparam logic [7:0]  MBURR_EXC_ILL_ADDR  = 8'h02;
    localparam logic [7:0]  MBURR_EXC_ILL_VALUE = 8'h03;
    typedef enum logic [1:0] {
        MBURR_ST_IDLE,
        MBURR_ST_RUN,
        MBURR_ST_DONE
    } mburr_state_t;
endpackage : mburr_pkg

/* logic/mburr_alias_table.sv */
`timescale 1ns/1ps
// Alias slot table: slot index to standard protocol address
module mburr_alias_table
    import mburr_pkg::*;
#(
    parameter int SLOTS  = MBURR_WIN_SLOTS,
    parameter int SLOT_W = MBURR_SLOT_W
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Configuration write port
    input  wire logic              cfg_we,
    input  wire logic [SLOT_W-1:0] cfg_slot,
    input  wire logic [15:0]       cfg_target,
    input  wire logic              cfg_valid,
    // Lookup
    input  wire logic [SLOT_W-1:0] look_slot,
    output logic      [15:0]       look_target,
    output logic                   look_valid
);
    import mburr_pkg::*;

    logic [15:0] target_reg [SLOTS];
    logic [SLOTS-1:0] valid_reg;

    // Any standard address may be stored; unassigned slots stay invalid
    always_ff @(posedge clk)
    begin
        if (cfg_we && (int'(cfg_slot) < SLOTS))
        begin
            target_reg[cfg_slot] <= cfg_target;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            valid_reg <= '0;
        end
        else if (cfg_we && (int'(cfg_slot) < SLOTS))
        begin
            valid_reg[cfg_slot] <= cfg_valid;
        end
    end

    always_comb
    begin
        if (int'(look_slot) < SLOTS)
        begin
            look_target = target_reg[look_slot];
            look_valid  = valid_reg[look_slot];
        end
        else
        begin
            look_target = 16'h0000;
            look_valid  = 1'b0;
        end
    end
endmodule : mburr_alias_table

/* logic/mburr_remap.sv */
`timescale 1ns/1ps
module mburr_remap
    import mburr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Decoded request from the frame layer
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [7:0]  req_func,
    input  wire logic [15:0] req_addr,
    input  wire logic [7:0]  req_count,
    input  wire logic [7:0]  req_obj_bytes,
    // Write data, one word per accepted word strobe
    input  wire logic [15:0] wdata,
    output logic             wdata_take,
    // Read data toward the frame layer
    output logic [15:0]      rdata,
    output logic             rdata_valid,
    // Request result
    output logic             done,
    output logic [7:0]       exc_code,
    // Standard register store
    output logic             std_we,
    output logic             std_re,
    output logic [15:0]      std_addr,
    output logic [15:0]      std_wdata,
    input  wire logic [15:0] std_rdata,
    // Alias configuration
    input  wire logic        cfg_we,
    input  wire logic [6:0]  cfg_slot,
    input  wire logic [15:0] cfg_target,
    input  wire logic        cfg_valid
);
    import mburr_pkg::*;

    localparam logic [15:0] WIN_LO = MBURR_WIN_FIRST_NUM - MBURR_NUM_TO_ADDR;
    localparam logic [15:0] WIN_HI = MBURR_WIN_LAST_NUM - MBURR_NUM_TO_ADDR;

    mburr_state_t state_reg;
    logic [15:0]  addr_reg;
    logic [7:0]   left_reg;
    logic         write_reg;
    logic         alias_reg;
    logic         rd_pend_reg;
    logic [7:0]   exc_reg;

    logic [16:0]  last_addr;
    logic         first_in_win;
    logic         last_in_win;
    logic         is_write;
    logic         is_read;
    logic [7:0]   chk_exc;
    logic [15:0]  look_target;
    logic         look_valid;
    logic [15:0]  eff_addr;
    logic         step;

    // Window occupancy of first and last address of the request
    always_comb
    begin
        last_addr = {1'b0, req_addr} + {9'h000, req_count} - 17'h00001;
        first_in_win = (req_addr >= WIN_LO) && (req_addr <= WIN_HI);
        last_in_win  = (last_addr >= {1'b0, WIN_LO})
                    && (last_addr <= {1'b0, WIN_HI});
        is_write = (req_func == MBURR_FN_WRITE_ONE)
                || (req_func == MBURR_FN_WRITE_MANY);
        is_read  = (req_func == MBURR_FN_READ_HOLD)
                || (req_func == MBURR_FN_READ_INP);
    end

    // Request checks; any failure stops all register traffic
    always_comb
    begin
        chk_exc = MBURR_EXC_NONE;
        if (!is_write && !is_read)
        begin
            chk_exc = MBURR_EXC_ILL_FUNC;
        end
        else if (req_count == 8'h00 || last_addr > 17'h0ffff)
        begin
            chk_exc = MBURR_EXC_ILL_ADDR;
        end
        else if (first_in_win != last_in_win
              || (req_addr < WIN_LO && last_addr > {1'b0, WIN_HI}))
        begin
            chk_exc = MBURR_EXC_ILL_ADDR;
        end
        else if (req_func == MBURR_FN_WRITE_MANY
              && req_count > MBURR_MAX_WRITE_CNT)
        begin
            chk_exc = MBURR_EXC_ILL_VALUE;
        end
        else if (req_func == MBURR_FN_WRITE_ONE && req_count != 8'h01)
        begin
            chk_exc = MBURR_EXC_ILL_VALUE;
        end
        else if (req_obj_bytes > MBURR_MAX_OBJ_BYTES)
        begin
            chk_exc = MBURR_EXC_ILL_VALUE;
        end
    end

    mburr_alias_table u_table (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .cfg_we      (cfg_we),
        .cfg_slot    (cfg_slot),
        .cfg_target  (cfg_target),
        .cfg_valid   (cfg_valid),
        .look_slot   (7'(addr_reg - WIN_LO)),
        .look_target (look_target),
        .look_valid  (look_valid)
    );

    // Alias words redirect to the stored target; standard ones pass through
    always_comb
    begin
        eff_addr = alias_reg ? look_target : addr_reg;
    end

    // Unassigned alias slots read as zero and swallow writes
    always_comb
    begin
        step = (state_reg == MBURR_ST_RUN) && !rd_pend_reg;
        std_addr  = eff_addr;
        std_we    = step && write_reg && (!alias_reg || look_valid);
        std_re    = step && !write_reg && (!alias_reg || look_valid);
        std_wdata = wdata;
        wdata_take = step && write_reg;
        req_ready = (state_reg == MBURR_ST_IDLE);
    end

    // Sequencer; the table never hides a standard address
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg   <= MBURR_ST_IDLE;
            addr_reg    <= 16'h0000;
            left_reg    <= 8'h00;
            write_reg   <= 1'b0;
            alias_reg   <= 1'b0;
            rd_pend_reg <= 1'b0;
            exc_reg     <= MBURR_EXC_NONE;
        end
        else
        begin
            case (state_reg)
                MBURR_ST_IDLE:
                begin
                    if (req_valid)
                    begin
                        addr_reg  <= req_addr;
                        left_reg  <= req_count;
                        write_reg <= is_write;
                        alias_reg <= first_in_win;
                        exc_reg   <= chk_exc;
                        state_reg <= (chk_exc == MBURR_EXC_NONE)
                                   ? MBURR_ST_RUN : MBURR_ST_DONE;
                    end
                end
                MBURR_ST_RUN:
                begin
                    if (write_reg || rd_pend_reg)
                    begin
                        rd_pend_reg <= 1'b0;
                        addr_reg    <= addr_reg + 16'h0001;
                        left_reg    <= left_reg - 8'h01;
                        if (left_reg == 8'h01)
                        begin
                            state_reg <= MBURR_ST_DONE;
                        end
                    end
                    else
                    begin
                        rd_pend_reg <= 1'b1;
                    end
                end
                MBURR_ST_DONE:
                begin
                    state_reg <= MBURR_ST_IDLE;
                end
                default:
                begin
                    state_reg <= MBURR_ST_IDLE;
                end
            endcase
        end
    end

    // Read data is latched one cycle after the store read strobe
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rdata       <= 16'h0000;
            rdata_valid <= 1'b0;
        end
        else
        begin
            rdata_valid <= (state_reg == MBURR_ST_RUN) && rd_pend_reg;
            if ((state_reg == MBURR_ST_RUN) && rd_pend_reg)
            begin
                rdata <= (!alias_reg || look_valid) ? std_rdata : 16'h0000;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            done     <= 1'b0;
            exc_code <= MBURR_EXC_NONE;
        end
        else
        begin
            done     <= (state_reg == MBURR_ST_DONE);
            exc_code <= (state_reg == MBURR_ST_DONE) ? exc_reg : exc_code;
        end
    end
endmodule : mburr_remap

/* verification/mburr_store_model.sv */
`timescale 1ns/1ps
// Standard register store seen by the remap block
module mburr_store_model (
    // Clock
    input  wire logic        clk,
    // Store port
    input  wire logic        std_we,
    input  wire logic [15:0] std_addr,
    input  wire logic [15:0] std_wdata,
    output logic      [15:0] std_rdata
);
    logic [15:0] mem [0:65535];

    // Known pattern so reads are predictable
    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem[i] = 16'(i) ^ 16'h5a5a;
    end

    // Plain always: the pattern preload above also writes the array
    always @(posedge clk)
    begin
        if (std_we)
            mem[std_addr] <= std_wdata;
    end

    // Read is combinational in the same cycle
    assign std_rdata = mem[std_addr];
endmodule : mburr_store_model

/* verification/mburr_remap_checker.sv */
`timescale 1ns/1ps
module mburr_remap_checker
    import mburr_pkg::*;
(
    input wire logic        clk, sys_rst, req_valid, req_ready,
    input wire logic [7:0]  req_func, req_count, req_obj_bytes,
    input wire logic [15:0] req_addr, wdata,
    input wire logic        wdata_take, rdata_valid, done,
    input wire logic [15:0] rdata,
    input wire logic [7:0]  exc_code,
    input wire logic        std_we, std_re,
    input wire logic [15:0] std_addr, std_wdata, std_rdata,
    input wire logic        cfg_we, cfg_valid,
    input wire logic [6:0]  cfg_slot,
    input wire logic [15:0] cfg_target
);
    localparam logic [15:0] WFA = MBURR_WIN_FIRST_NUM - MBURR_NUM_TO_ADDR;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_done_exc(logic [7:0] c);
        done && exc_code == c;
    endsequence

    property p_busy;
        s_take |=> !req_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready after take");
    property p_refused;
        done && exc_code != MBURR_EXC_NONE |-> !$past(std_we) && !$past(std_re);
    endproperty
    a_refused: assert property (p_refused)
        else $error("store touched by refused request");
    property p_read;
        std_re |-> ##2 rdata_valid && rdata == $past(std_rdata);
    endproperty
    a_read: assert property (p_read)
        else $error("read word lost");
    property p_wdata;
        std_we |-> wdata_take && std_wdata == wdata;
    endproperty
    a_wdata: assert property (p_wdata) else $error("write word");
    property p_ascend;
        std_we ##1 std_we |-> std_addr == $past(std_addr) + 16'h0001;
    endproperty
    a_ascend: assert property (p_ascend) else $error("address order");
    property p_many;
        s_take ##0 (req_func == MBURR_FN_WRITE_MANY
            && req_count > MBURR_MAX_WRITE_CNT && req_addr < WFA - 16'h0100)
            |-> ##2 s_done_exc(MBURR_EXC_ILL_VALUE);
    endproperty
    a_many: assert property (p_many) else $error("oversize write");
    property p_obj;
        s_take ##0 (req_func == MBURR_FN_READ_HOLD && req_count == 8'h01
            && req_addr < WFA && req_obj_bytes > MBURR_MAX_OBJ_BYTES)
            |-> ##2 s_done_exc(MBURR_EXC_ILL_VALUE);
    endproperty
    a_obj: assert property (p_obj) else $error("object length");
    property p_mixed;
        s_take ##0 (req_func == MBURR_FN_READ_HOLD && req_addr == WFA - 16'h1
            && req_count == 8'h02 && req_obj_bytes <= MBURR_MAX_OBJ_BYTES)
            |-> ##2 s_done_exc(MBURR_EXC_ILL_ADDR);
    endproperty
    a_mixed: assert property (p_mixed) else $error("mixed span");
    property p_w1;
        s_take ##0 (req_func == MBURR_FN_WRITE_ONE && req_count == 8'h01
            && req_addr < WFA && req_obj_bytes <= MBURR_MAX_OBJ_BYTES)
            |=> std_we && std_addr == $past(req_addr)
            ##2 s_done_exc(MBURR_EXC_NONE);
    endproperty
    a_w1: assert property (p_w1) else $error("single write");
endmodule : mburr_remap_checker

bind mburr_remap mburr_remap_checker chk (.*);

/* verification/mburr_remap_tb.sv */
`timescale 1ns/1ps
module mburr_remap_tb;
    import mburr_pkg::*;
    typedef struct {logic [7:0] f; logic [15:0] a; logic [7:0] n, ob, ex;}
        mburr_row_t;
    logic        clk, sys_rst, req_valid, req_ready, wdata_take, rdata_valid;
    logic        done, std_we, std_re, cfg_we, cfg_valid;
    logic [7:0]  req_func, req_count, req_obj_bytes, exc_code, ex;
    logic [15:0] req_addr, wdata, rdata, std_addr, std_wdata, std_rdata;
    logic [15:0] cfg_target, rd;
    logic [6:0]  cfg_slot;
    int          n_errors, total_checks;
    mburr_row_t  rows [13] = '{
        '{8'h03, 16'h0010, 8'h01, 8'h02, 8'h00}, '{8'h04, 16'h0011, 8'h03,
        8'h40, 8'h00}, '{8'h03, 16'ha777, 8'h02, 8'h02, 8'h02}, '{8'h03,
        16'ha7f5, 8'h0a, 8'h02, 8'h02}, '{8'h05, 16'h0010, 8'h01, 8'h02,
        8'h01}, '{8'h10, 16'h0100, 8'h11, 8'h02, 8'h03}, '{8'h10, 16'h0100,
        8'h10, 8'h02, 8'h00}, '{8'h06, 16'h0100, 8'h02, 8'h02, 8'h03},
        '{8'h03, 16'h0010, 8'h01, 8'h41, 8'h03}, '{8'h03, 16'h0010, 8'h00,
        8'h02, 8'h02}, '{8'h03, 16'hffff, 8'h02, 8'h02, 8'h02}, '{8'h06,
        16'h0200, 8'h01, 8'h02, 8'h00}, '{8'h03, 16'ha770, 8'h90, 8'h02,
        8'h02}};

    mburr_remap dut (.*);
    mburr_store_model store (.clk(clk), .std_we(std_we), .std_addr(std_addr),
        .std_wdata(std_wdata), .std_rdata(std_rdata));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic ck(input logic [15:0] seen, exp, input string nm);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : ck

    task automatic xfer(input logic [7:0] f, input logic [15:0] a,
                        input logic [7:0] n, ob, input logic [15:0] wd);
        @(posedge clk);
        #2 {req_func, req_addr, req_count, req_obj_bytes} = {f, a, n, ob};
        wdata = wd;
        req_valid = 1'b1;
        @(posedge clk);
        #2 req_valid = 1'b0;
        for (int i = 0; i < 100; i++)
        begin
            @(posedge clk);
            #1 if (rdata_valid === 1'b1) rd = rdata;
            if (done === 1'b1) break;
            if (i == 99) ck(1'b0, 1'b1, "done");
        end
        ex = exc_code;
    endtask : xfer

    task automatic cfg(input logic [6:0] s, input logic [15:0] t);
        @(posedge clk);
        #2 {cfg_we, cfg_slot, cfg_target, cfg_valid} = {1'b1, s, t, 1'b1};
        @(posedge clk);
        #2 cfg_we = 1'b0;
    endtask : cfg

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    initial
    begin
        #200000;
        n_errors++;
        results;
    end

    initial
    begin
        {req_valid, req_func, req_addr, req_count, req_obj_bytes} = '0;
        {wdata, cfg_we, cfg_slot, cfg_target, cfg_valid} = '0;
        sys_rst = 1'b1;
        repeat (6) @(posedge clk);
        #2 sys_rst = 1'b0;
        foreach (rows[i])
        begin
            xfer(rows[i].f, rows[i].a, rows[i].n, rows[i].ob, 16'h1234);
            ck(ex, rows[i].ex, "exc_code");
            if (rows[i].ex == 8'h00 && rows[i].f < 8'h05)
                ck(rd, (rows[i].a + rows[i].n - 1) ^ 16'h5a5a, "rdata");
            $display("row %0d done", i);
        end
        xfer(8'h03, 16'h0107, 8'h01, 8'h02, 16'h0);
        ck(rd, 16'h1234, "rdata");
        // Refused writes must leave the store untouched
        xfer(8'h10, 16'h0300, 8'h11, 8'h02, 16'hdead);
        ck(ex, 8'h03, "big_wr");
        xfer(8'h10, 16'ha776, 8'h03, 8'h02, 16'hdead);
        ck(ex, 8'h02, "mixed_wr");
        xfer(8'h03, 16'h0300, 8'h01, 8'h02, 16'h0);
        ck(rd, 16'h0300 ^ 16'h5a5a, "kept_std");
        xfer(8'h03, 16'ha776, 8'h01, 8'h02, 16'h0);
        ck(rd, 16'ha776 ^ 16'h5a5a, "kept_mixed");
        $display("refusal done");
        // Slot assigned before reset must read as unassigned after it
        cfg(7'h01, 16'h0040);
        // Reset while idle clears the result and slots
        @(posedge clk);
        #2 sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 ck({req_ready, done, exc_code}, {2'b10, 8'h00}, "reset");
        ck(rdata, 16'h0, "reset_rdata");
        #1 sys_rst = 1'b0;
        $display("reset done");
        cfg(7'h00, 16'h0020);
        xfer(8'h06, 16'ha778, 8'h01, 8'h02, 16'hbeef);
        ck(ex, 8'h00, "alias_wr");
        xfer(8'h03, 16'h0020, 8'h01, 8'h02, 16'h0);
        ck(rd, 16'hbeef, "orig_rd");
        xfer(8'h03, 16'ha778, 8'h01, 8'h02, 16'h0);
        ck(rd, 16'hbeef, "alias_rd");
        cfg(7'h7e, 16'h0030);
        xfer(8'h03, 16'ha7f6, 8'h01, 8'h02, 16'h0);
        ck(rd, 16'h0030 ^ 16'h5a5a, "last_slot");
        xfer(8'h03, 16'ha779, 8'h01, 8'h02, 16'h0);
        ck(rd, 16'h0, "unassigned");
        $display("alias done");
        results;
    end
endmodule : mburr_remap_tb
